// ### rtl/bgdc_regs.svh
// bgdc_regs.svh: register map, field positions, reset values and timing counts
// assumes a 50 MHz clock and an apb slave with 32-bit data
`ifndef BGDC_REGS_SVH
`define BGDC_REGS_SVH
`define BGDC_CTRL_OFS 12'h000
`define BGDC_STAT_OFS 12'h004
`define BGDC_DEAD_OFS 12'h008
`define BGDC_OFF_OFS 12'h00C
`define BGDC_BLANK_OFS 12'h010
`define BGDC_CTRL_DECAY_BIT 0
`define BGDC_CTRL_PWM_BIT 1
`define BGDC_CTRL_SYNC_BIT 2
`define BGDC_CTRL_RST_BIT 3
`define BGDC_CTRL_DIR_BIT 4
`define BGDC_CTRL_RST 32'h0000_0009
`define BGDC_DEAD_NS 100
`define BGDC_CLK_NS 20
`define BGDC_DEAD_CYC ((`BGDC_DEAD_NS + `BGDC_CLK_NS - 1) / `BGDC_CLK_NS)
`define BGDC_OFF_US 10
`define BGDC_OFF_CYC ((`BGDC_OFF_US * 1000 + `BGDC_CLK_NS - 1) / `BGDC_CLK_NS)
`define BGDC_BLANK_NS 1000
`define BGDC_BLANK_CYC ((`BGDC_BLANK_NS + `BGDC_CLK_NS - 1) / `BGDC_CLK_NS)
`endif

// ### rtl/bgdc_pkg.sv
// bgdc_pkg.sv: types shared by the gate-drive control block
// assumes nothing beyond the register header
package bgdc_pkg;
   typedef struct packed {
      logic [2:0] high_side_gate;
      logic [2:0] low_side_gate;
   } bgdc_gates_s;
   typedef struct packed {
      logic hall_bad;
      logic uvlo;
      logic thermal;
      logic short_gnd;
   } bgdc_faults_s;
   typedef enum logic [1:0] {
      BGDC_RUN = 2'b00,
      BGDC_OFF = 2'b01,
      BGDC_BLANK = 2'b10
   } bgdc_chop_e;
endpackage

// ### rtl/bgdc_top.sv
// bgdc_top.sv: gate-drive control logic of a three-phase bridge controller
// assumes synchronous inputs, apb master on the register side, analog monitors as levels
// How it works
// - fast decay, pwm low, no sr: all off
// - pwm high drives commutation-selected gates
// - slow decay off time: selected low side only
// - fast decay with sr: complement drivers on
// - slow decay with sr: both low sides
// - reset forces gates off, clears short fault
// - body diodes conduct only during dead time with sr on
// - dead time between any off and on
// - high side waits for bootstrap charge, no fault
// - hall 000 or 111 faults and coasts
// - gates low until gate supply is good
// - thermal fault with auto clear on hysteresis
// - high-side drop after turn-on flags short
// - commutation step clears latched short fault
// - stalled short clears only by reset toggle
// - current trip cuts high side for off time
// - off time end restores selected high side
// - sense ignored during blanking after turn-on
// - slow decay cuts high only, fast cuts both
// - short fault cuts high sides; others all
// - fault output for any of four faults
`timescale 1ns/100ps
`include "bgdc_regs.svh"
module bgdc_top
   import bgdc_pkg::*;
#(
   parameter int DEAD_CYC = `BGDC_DEAD_CYC,
   parameter int OFF_CYC = `BGDC_OFF_CYC,
   parameter int BLANK_CYC = `BGDC_BLANK_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] hall_sensor_inputs,
   input wire logic gate_supply_ok,
   input wire logic over_temp_hi,
   input wire logic under_temp_lo,
   input wire logic high_side_drop_hi,
   input wire logic boot_charge_busy,
   input wire logic current_trip,
   output bgdc_gates_s gates,
   output logic fault
);
   // ************
   // register file
   // ************
   logic [31:0] ctrl_q;
   logic [15:0] dead_q;
   logic [15:0] off_q;
   logic [15:0] blank_q;
   bgdc_faults_s flt;
   logic bad_hall;
   logic low_supply;
   logic thermal_q;
   logic short_q;
   bgdc_chop_e chop_q;
   logic wr_en;
   logic hit;
   logic slow_decay;
   logic pwm_in;
   logic sr_en;
   logic rst_req;
   logic dir;
   assign wr_en = psel & penable & pwrite;
   assign pready = 1'b1;
   assign hit = (paddr == `BGDC_CTRL_OFS) || (paddr == `BGDC_STAT_OFS) ||
                (paddr == `BGDC_DEAD_OFS) || (paddr == `BGDC_OFF_OFS) ||
                (paddr == `BGDC_BLANK_OFS);
   assign pslverr = psel & penable & ~hit;
   assign slow_decay = ctrl_q[`BGDC_CTRL_DECAY_BIT];
   assign pwm_in = ctrl_q[`BGDC_CTRL_PWM_BIT];
   assign sr_en = ctrl_q[`BGDC_CTRL_SYNC_BIT];
   assign rst_req = ctrl_q[`BGDC_CTRL_RST_BIT];
   assign dir = ctrl_q[`BGDC_CTRL_DIR_BIT];
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= `BGDC_CTRL_RST;
         dead_q <= 16'h0000;
         off_q <= 16'h0000;
         blank_q <= 16'h0000;
      end else if (clk_en && wr_en) begin
         if (paddr == `BGDC_CTRL_OFS && pstrb[0]) begin
            ctrl_q <= {27'h0, pwdata[4:0]};
         end
         if (paddr == `BGDC_DEAD_OFS) begin
            if (pstrb[0]) dead_q[7:0] <= pwdata[7:0];
            if (pstrb[1]) dead_q[15:8] <= pwdata[15:8];
         end
         if (paddr == `BGDC_OFF_OFS) begin
            if (pstrb[0]) off_q[7:0] <= pwdata[7:0];
            if (pstrb[1]) off_q[15:8] <= pwdata[15:8];
         end
         if (paddr == `BGDC_BLANK_OFS) begin
            if (pstrb[0]) blank_q[7:0] <= pwdata[7:0];
            if (pstrb[1]) blank_q[15:8] <= pwdata[15:8];
         end
      end
   end
   // zero in a timing register selects the parameter default
   logic [15:0] dead_n;
   logic [15:0] off_n;
   logic [15:0] blank_n;
   assign dead_n = (dead_q != 16'h0000) ? dead_q : 16'(DEAD_CYC);
   assign off_n = (off_q != 16'h0000) ? off_q : 16'(OFF_CYC);
   assign blank_n = (blank_q != 16'h0000) ? blank_q : 16'(BLANK_CYC);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else if (clk_en && psel && !penable && !pwrite) begin
         unique case (paddr)
            `BGDC_CTRL_OFS: prdata <= ctrl_q;
            `BGDC_STAT_OFS: prdata <= {25'h0, chop_q, fault, flt};
            `BGDC_DEAD_OFS: prdata <= {16'h0000, dead_q};
            `BGDC_OFF_OFS: prdata <= {16'h0000, off_q};
            `BGDC_BLANK_OFS: prdata <= {16'h0000, blank_q};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
   // ************
   // commutation and faults
   // ************
   logic [2:0] sel_hi;
   logic [2:0] sel_lo;
   logic [2:0] hall_q;
   logic step;
   always_comb begin
      sel_hi = 3'h0;
      sel_lo = 3'h0;
      unique case ({hall_sensor_inputs, dir})
         4'hB: begin sel_hi = 3'h1; sel_lo = 3'h4; end
         4'h9: begin sel_hi = 3'h2; sel_lo = 3'h4; end
         4'hD: begin sel_hi = 3'h2; sel_lo = 3'h1; end
         4'h5: begin sel_hi = 3'h4; sel_lo = 3'h1; end
         4'h7: begin sel_hi = 3'h4; sel_lo = 3'h2; end
         4'h3: begin sel_hi = 3'h1; sel_lo = 3'h2; end
         4'hA: begin sel_hi = 3'h4; sel_lo = 3'h1; end
         4'h8: begin sel_hi = 3'h4; sel_lo = 3'h2; end
         4'hC: begin sel_hi = 3'h1; sel_lo = 3'h2; end
         4'h4: begin sel_hi = 3'h1; sel_lo = 3'h4; end
         4'h6: begin sel_hi = 3'h2; sel_lo = 3'h4; end
         4'h2: begin sel_hi = 3'h2; sel_lo = 3'h1; end
         default: begin sel_hi = 3'h0; sel_lo = 3'h0; end
      endcase
   end
   assign bad_hall = (hall_sensor_inputs == 3'h0) || (hall_sensor_inputs == 3'h7);
   assign low_supply = ~gate_supply_ok;
   assign flt = {bad_hall, low_supply, thermal_q, short_q};
   assign step = (hall_q != hall_sensor_inputs);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hall_q <= 3'h0;
      end else if (clk_en) begin
         hall_q <= hall_sensor_inputs;
      end
   end
   // thermal flag holds between the two trip points
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         thermal_q <= 1'b0;
      end else if (clk_en) begin
         if (over_temp_hi) thermal_q <= 1'b1;
         else if (under_temp_lo) thermal_q <= 1'b0;
      end
   end
   // ************
   // gate decision and dead time
   // ************
   bgdc_gates_s want;
   bgdc_gates_s gates_q;
   logic [15:0] dead_cnt_q;
   logic [15:0] chop_cnt_q;
   logic hi_armed;
   assign hi_armed = (chop_q != BGDC_OFF) & pwm_in;
   always_comb begin
      want = '0;
      if (rst_req || flt.hall_bad || flt.uvlo || flt.thermal) begin
         want = '0;
      end else if (hi_armed) begin
         want.high_side_gate = sel_hi;
         want.low_side_gate = sel_lo;
      end else if (!slow_decay && !sr_en) begin
         want = '0;
      end else if (slow_decay && !sr_en) begin
         want.low_side_gate = sel_lo;
      end else if (!slow_decay) begin
         want.high_side_gate = sel_lo;
         want.low_side_gate = sel_hi;
      end else begin
         want.low_side_gate = sel_hi | sel_lo;
      end
      if (flt.short_gnd) want.high_side_gate = 3'h0;
      if (boot_charge_busy) want.high_side_gate = 3'h0;
   end
   // any gate dropping starts a dead gap; gates still wanted stay on and no gate rises until the gap has run out
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gates_q <= '0;
         dead_cnt_q <= 16'h0000;
      end else if (clk_en) begin
         if ((gates_q & ~want) != '0) begin
            gates_q <= gates_q & want;
            dead_cnt_q <= dead_n;
         end else if (dead_cnt_q != 16'h0000) begin
            dead_cnt_q <= dead_cnt_q - 16'h0001;
         end else begin
            gates_q <= want;
         end
      end
   end
   assign gates = gates_q;
   // ************
   // off time and blanking
   // ************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         chop_q <= BGDC_BLANK;
         chop_cnt_q <= 16'h0000;
      end else if (clk_en) begin
         unique case (chop_q)
            BGDC_RUN: begin
               if (current_trip) begin
                  chop_q <= BGDC_OFF;
                  chop_cnt_q <= off_n;
               end
            end
            BGDC_OFF: begin
               if (chop_cnt_q <= 16'h0001) begin
                  chop_q <= BGDC_BLANK;
                  chop_cnt_q <= blank_n;
               end else begin
                  chop_cnt_q <= chop_cnt_q - 16'h0001;
               end
            end
            BGDC_BLANK: begin
               if (gates_q.high_side_gate == 3'h0) begin
                  chop_cnt_q <= blank_n;
               end else if (chop_cnt_q <= 16'h0001) begin
                  chop_q <= BGDC_RUN;
                  chop_cnt_q <= 16'h0000;
               end else begin
                  chop_cnt_q <= chop_cnt_q - 16'h0001;
               end
            end
            default: chop_q <= BGDC_RUN;
         endcase
      end
   end
   // ************
   // short to ground
   // ************
   // the drop is judged only once the high side has settled past blanking
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         short_q <= 1'b0;
      end else if (clk_en) begin
         if (rst_req) begin
            short_q <= 1'b0;
         end else if (gates_q.high_side_gate != 3'h0 && chop_q == BGDC_RUN &&
                      high_side_drop_hi) begin
            short_q <= 1'b1;
         end else if (step) begin
            short_q <= 1'b0;
         end
      end
   end
   assign fault = flt.hall_bad | flt.uvlo | flt.thermal | flt.short_gnd;
   // ************
   // checks
   // ************
   AST_RESET_OFF: assert property (@(posedge clk) disable iff (!nrst)
      rst_req && clk_en |=> gates == '0) else $error("gates on under reset");
   AST_HALL_FAULT: assert property (@(posedge clk) disable iff (!nrst)
      flt.hall_bad && clk_en |=> gates == '0) else $error("gates on with bad hall code");
   AST_UVLO_OFF: assert property (@(posedge clk) disable iff (!nrst)
      flt.uvlo && clk_en |=> gates == '0) else $error("gates on with low supply");
   AST_SHORT_HI: assert property (@(posedge clk) disable iff (!nrst)
      flt.short_gnd && clk_en |=> gates.high_side_gate == 3'h0)
      else $error("high side on with short fault");
   AST_NO_SHOOT: assert property (@(posedge clk) disable iff (!nrst)
      (gates.high_side_gate & gates.low_side_gate) == 3'h0)
      else $error("both gates of a phase on");
   AST_DEAD_GAP: assert property (@(posedge clk) disable iff (!nrst)
      clk_en && $past(clk_en) && (($past(gates) & ~gates) != '0) |-> dead_cnt_q != 16'h0000)
      else $error("dead time not started");
   AST_TRIP_OFF: assert property (@(posedge clk) disable iff (!nrst)
      chop_q == BGDC_RUN && current_trip && clk_en |=> chop_q == BGDC_OFF)
      else $error("trip did not start off time");
   AST_FAULT_OR: assert property (@(posedge clk) disable iff (!nrst)
      fault == (flt != '0)) else $error("fault output mismatch");
   AST_BOOT: assert property (@(posedge clk) disable iff (!nrst)
      boot_charge_busy && clk_en |=> gates.high_side_gate == 3'h0 || !$past(clk_en))
      else $error("high side on while bootstrap charging");
   // ************
   // decay table, fault and chopper checks
   // ************
   // each check but AST_ONE_HI looks one enabled edge ahead, the gate register settles in one cycle

   AST_FAST_OFF: assert property (@(posedge clk) disable iff (!nrst)
      clk_en && !pwm_in && !slow_decay && !sr_en |=> gates == '0)
      else $error("gates on in fast decay off time");

   AST_SLOW_HI: assert property (@(posedge clk) disable iff (!nrst)
      clk_en && !pwm_in && slow_decay && !sr_en |=> gates.high_side_gate == 3'h0)
      else $error("high side on in slow decay off time");

   AST_SLOW_SR: assert property (@(posedge clk) disable iff (!nrst)
      clk_en && !pwm_in && slow_decay && sr_en |=> gates.high_side_gate == 3'h0)
      else $error("high side on in slow decay with sr");

   AST_ONE_HI: assert property (@(posedge clk) disable iff (!nrst)
      $onehot0(gates.high_side_gate))
      else $error("more than one high side on");

   AST_DEAD_HOLD: assert property (@(posedge clk) disable iff (!nrst)
      dead_cnt_q != 16'h0000 && clk_en |=> (gates & ~$past(gates)) == '0)
      else $error("gate rose inside dead time");

   // thermal flag must keep its value between the two trip points
   AST_THERM_SET: assert property (@(posedge clk) disable iff (!nrst)
      over_temp_hi && clk_en |=> flt.thermal)
      else $error("thermal fault not set");

   AST_THERM_HOLD: assert property (@(posedge clk) disable iff (!nrst)
      flt.thermal && !under_temp_lo && clk_en |=> flt.thermal)
      else $error("thermal fault dropped early");

   AST_THERM_CLR: assert property (@(posedge clk) disable iff (!nrst)
      !over_temp_hi && under_temp_lo && clk_en |=> !flt.thermal)
      else $error("thermal fault not cleared");

   AST_THERM_OFF: assert property (@(posedge clk) disable iff (!nrst)
      flt.thermal && clk_en |=> gates == '0)
      else $error("gates on with thermal fault");

   AST_SHORT_SET: assert property (@(posedge clk) disable iff (!nrst)
      !rst_req && gates.high_side_gate != 3'h0 && chop_q == BGDC_RUN &&
      high_side_drop_hi && clk_en |=> flt.short_gnd)
      else $error("short to ground not flagged");

   AST_SHORT_STEP: assert property (@(posedge clk) disable iff (!nrst)
      flt.short_gnd && step && !high_side_drop_hi && clk_en |=> !flt.short_gnd)
      else $error("short fault not cleared by commutation");

   // a stalled motor gives no step, so only the reset bit may free it
   AST_SHORT_HOLD: assert property (@(posedge clk) disable iff (!nrst)
      flt.short_gnd && !step && !rst_req && clk_en |=> flt.short_gnd)
      else $error("short fault dropped without step or reset");

   AST_RST_CLR: assert property (@(posedge clk) disable iff (!nrst)
      rst_req && clk_en |=> !flt.short_gnd)
      else $error("reset did not clear short fault");

   AST_RUN_STAY: assert property (@(posedge clk) disable iff (!nrst)
      chop_q == BGDC_RUN && !current_trip && clk_en |=> chop_q == BGDC_RUN)
      else $error("off time without trip");

   AST_OFF_HI: assert property (@(posedge clk) disable iff (!nrst)
      chop_q == BGDC_OFF && !sr_en && clk_en |=> gates.high_side_gate == 3'h0)
      else $error("high side on during off time");

   AST_OFF_END: assert property (@(posedge clk) disable iff (!nrst)
      chop_q == BGDC_OFF && chop_cnt_q <= 16'h0001 && clk_en |=> chop_q == BGDC_BLANK)
      else $error("off time did not end");

   // the comparator is deaf until blanking has run out with a high side on
   AST_BLANK_IGN: assert property (@(posedge clk) disable iff (!nrst)
      chop_q == BGDC_BLANK && clk_en |=> chop_q != BGDC_OFF)
      else $error("trip taken during blanking");

   AST_BLANK_HOLD: assert property (@(posedge clk) disable iff (!nrst)
      chop_q == BGDC_BLANK && gates.high_side_gate == 3'h0 && clk_en |=> chop_q == BGDC_BLANK)
      else $error("blanking ended with high side off");
endmodule

// ### bench/bgdc_bridge.sv
// bgdc_bridge.sv: behavioural bridge, winding current and high-side monitors
// assumes gates come from the controller on the same clock
`timescale 1ns/100ps
module bgdc_bridge
   import bgdc_pkg::*;
#(
   parameter int TRIP = 12,
   parameter int BOOT = 3
) (
   input wire logic clk,
   input wire logic nrst,
   input wire bgdc_gates_s gates,
   input wire logic short_en,
   input wire logic trip_en,
   output logic high_side_drop_hi,
   output logic boot_charge_busy,
   output logic current_trip
);
   int cur;
   int boot;
   logic [2:0] low_q;
   // a short only shows while a high side conducts into it
   assign high_side_drop_hi = short_en && (gates.high_side_gate != 3'h0);
   // trip gated so other scenarios see steady gates
   assign current_trip = trip_en && (cur >= TRIP);
   assign boot_charge_busy = (boot != 0);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cur <= 0;
         boot <= 0;
         low_q <= 3'h0;
      end else begin
         low_q <= gates.low_side_gate;
         if (gates.high_side_gate != 3'h0 && gates.low_side_gate != 3'h0) begin
            cur <= cur + 1;
         end else if (cur > 0) begin
            cur <= cur - 1;
         end
         // bootstrap recharge current lingers after a low side opens
         if ((low_q & ~gates.low_side_gate) != 3'h0) begin
            boot <= BOOT;
         end else if (boot > 0) begin
            boot <= boot - 1;
         end
      end
   end
endmodule

// ### bench/tb.sv
// tb.sv: self-checking bench for the gate-drive control block
// assumes the bridge model in bgdc_bridge.sv and the apb register map header
`timescale 1ns/100ps
`include "bgdc_regs.svh"
module tb;
   import bgdc_pkg::*;
   localparam int DEAD = 2;
   localparam int OFF = 8;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, fault, err;
   logic ok, hot, cold, drop, busy, trip, short_en, trip_en, en;
   logic [2:0] hall;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   bgdc_gates_s gates;
   int error_cnt = 0;
   int n_compared = 0;
   int gap, n;
   logic [4:0] mode_t [5] = '{5'h13, 5'h11, 5'h10, 5'h14, 5'h15};
   bgdc_gates_s exp_t [5] = '{6'h0C, 6'h04, 6'h00, 6'h21, 6'h05};
   bgdc_top #(.DEAD_CYC(DEAD), .OFF_CYC(OFF), .BLANK_CYC(4)) bgdc_top_i (.clk(clk),
      .nrst(nrst), .clk_en(en), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .hall_sensor_inputs(hall), .gate_supply_ok(ok),
      .over_temp_hi(hot), .under_temp_lo(cold), .high_side_drop_hi(drop),
      .boot_charge_busy(busy), .current_trip(trip), .gates(gates), .fault(fault));
   bgdc_bridge bgdc_bridge_i (.clk(clk), .nrst(nrst), .gates(gates), .short_en(short_en),
      .trip_en(trip_en), .high_side_drop_hi(drop), .boot_charge_busy(busy),
      .current_trip(trip));
   // ********************
   // tasks
   // ********************
   task automatic close_out();
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk_v(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk_g(input bgdc_gates_s e);
      chk_v("gates", {26'h0, e}, {26'h0, gates});
   endtask
   // pready is only waited for, never assumed
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         error_cnt++;
         close_out();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // counts cycles spent on a subset of the target gates, i.e. the dead gap
   task automatic wait_g(input bgdc_gates_s e);
      gap = 0;
      for (n = 0; n < 60 && gates !== e; n++) begin
         @(posedge clk);
         if ((gates & ~e) == 6'h00 && gates !== e) gap++;
      end
      chk_g(e);
   endtask
   task automatic bad_in(input logic [2:0] h, input logic o, input logic t);
      hall <= h;
      ok <= o;
      hot <= t;
      cold <= !t;
      wait_g(6'h00);
      chk_v("fault", 1, fault);
      hot <= 1'b0;
      repeat (3) @(posedge clk);
      chk_v("fault held", 1, fault);
      hall <= 3'b101;
      ok <= 1'b1;
      cold <= 1'b1;
      wait_g(6'h0C);
      chk_v("fault", 0, fault);
   endtask
   // ********************
   // sequence
   // ********************
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      {nrst, psel, penable, pwrite, paddr, pwdata, hot, short_en, trip_en} = '0;
      {en, ok, cold, hall} = 6'h3D;
      repeat (6) @(posedge clk);
      chk_g(6'h00);
      nrst <= 1'b1;
      apb(1'b0, `BGDC_CTRL_OFS, 32'h0);
      chk_v("ctrl", 32'h09, rd);
      apb(1'b0, 12'h020, 32'h0);
      chk_v("slverr", 1, err);
      apb(1'b1, `BGDC_DEAD_OFS, 32'h0000_0003);
      apb(1'b0, `BGDC_DEAD_OFS, 32'h0);
      chk_v("dead", 32'h3, rd);
      for (int k = 0; k < 5; k++) begin
         apb(1'b1, `BGDC_CTRL_OFS, {27'h0, mode_t[k]});
         wait_g(exp_t[k]);
      end
      chk_v("gap", 1, gap >= DEAD);
      chk_v("boot", 0, fault);
      apb(1'b1, `BGDC_CTRL_OFS, 32'h03);
      wait_g(6'h21);
      apb(1'b1, `BGDC_CTRL_OFS, 32'h13);
      wait_g(6'h0C);
      bad_in(3'b000, 1'b1, 1'b0);
      bad_in(3'b111, 1'b1, 1'b0);
      bad_in(3'b101, 1'b0, 1'b0);
      bad_in(3'b101, 1'b1, 1'b1);
      short_en <= 1'b1;
      wait_g(6'h04);
      short_en <= 1'b0;
      repeat (3) @(posedge clk);
      chk_v("short held", 1, fault);
      apb(1'b0, `BGDC_STAT_OFS, 32'h0);
      chk_v("stat", 32'h11, rd);
      hall <= 3'b100;
      wait_g(6'h14);
      chk_v("fault", 0, fault);
      short_en <= 1'b1;
      wait_g(6'h04);
      short_en <= 1'b0;
      apb(1'b1, `BGDC_CTRL_OFS, 32'h1B);
      wait_g(6'h00);
      apb(1'b1, `BGDC_CTRL_OFS, 32'h13);
      wait_g(6'h14);
      chk_v("fault", 0, fault);
      en <= 1'b0;
      hall <= 3'b101;
      repeat (4) @(posedge clk);
      chk_g(6'h14);
      hall <= 3'b100;
      en <= 1'b1;
      trip_en <= 1'b1;
      wait_g(6'h04);
      trip_en <= 1'b0;
      wait_g(6'h14);
      chk_v("off time", 1, n >= OFF - 1);
      close_out();
   end
endmodule
